// ==== cset_pkg.sv ====
package cset_pkg;
   // register addresses on the serial programming port
   localparam logic [9:0] CSET_A_SUB_CLEAR_START_POLARITY = 10'h271;
   localparam logic [9:0] CSET_A_SUB_CLEAR1_TOGGLE1_LO = 10'h272;
   localparam logic [9:0] CSET_A_SUB_CLEAR1_TOGGLE1_HI = 10'h273;
   localparam logic [9:0] CSET_A_SUB_CLEAR1_TOGGLE2_LO = 10'h274;
   localparam logic [9:0] CSET_A_SUB_CLEAR1_TOGGLE2_HI = 10'h275;
   localparam logic [9:0] CSET_A_SUB_CLEAR2_TOGGLE1_LO = 10'h276;
   localparam logic [9:0] CSET_A_SUB_CLEAR2_TOGGLE1_HI = 10'h277;
   localparam logic [9:0] CSET_A_SUB_CLEAR2_TOGGLE2_LO = 10'h278;
   localparam logic [9:0] CSET_A_SUB_CLEAR2_TOGGLE2_HI = 10'h279;
   localparam logic [9:0] CSET_A_SUB_CLEAR_COUNT_LO = 10'h27a;
   localparam logic [9:0] CSET_A_SUB_CLEAR_COUNT_HI = 10'h27b;
   localparam logic [9:0] CSET_A_SUB_CLEAR_GATE_SUPPRESS = 10'h27c;
   localparam logic [9:0] CSET_A_EXPOSURE_FIELDS_LO = 10'h27d;
   localparam logic [9:0] CSET_A_EXPOSURE_FIELDS_HI = 10'h27e;
   localparam logic [9:0] CSET_A_SYNC_OFF_IN_EXPOSURE = 10'h27f;
   localparam logic [9:0] CSET_A_SEQUENCE_TRIGGER = 10'h280;
   localparam logic [9:0] CSET_A_READOUT_CLEAR_SUPPRESS = 10'h281;
   localparam logic [9:0] CSET_A_BIAS_READOUT_MODE = 10'h282;
   localparam logic [9:0] CSET_A_BIAS_KEEP_ACTIVE = 10'h283;
   localparam logic [9:0] CSET_A_BIAS_POLARITY = 10'h284;
   localparam logic [9:0] CSET_A_BIAS_ON_POS_LO = 10'h285;
   localparam logic [9:0] CSET_A_BIAS_ON_POS_HI = 10'h286;
   localparam logic [9:0] CSET_A_SHUTTER_ENABLE = 10'h287;
   localparam logic [9:0] CSET_A_SHUTTER_POLARITY = 10'h288;
   localparam logic [9:0] CSET_A_SHUTTER_ON_LINE_LO = 10'h289;
   localparam logic [9:0] CSET_A_SHUTTER_ON_LINE_HI = 10'h28a;
   localparam logic [9:0] CSET_A_SHUTTER_ON_PIXEL_LO = 10'h28b;
   localparam logic [9:0] CSET_A_SHUTTER_ON_PIXEL_HI = 10'h28c;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_FIELD_LO = 10'h28d;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_FIELD_HI = 10'h28e;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_LINE_LO = 10'h28f;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_LINE_HI = 10'h290;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_PIXEL_LO = 10'h291;
   localparam logic [9:0] CSET_A_SHUTTER_OFF_PIXEL_HI = 10'h292;
   localparam logic [9:0] CSET_A_FLASH_POLARITY = 10'h293;
   localparam logic [9:0] CSET_A_FLASH_ON_FIELD_LO = 10'h294;
   localparam logic [9:0] CSET_A_FLASH_ON_FIELD_HI = 10'h295;
   localparam logic [9:0] CSET_A_FLASH_ON_LINE_LO = 10'h296;
   localparam logic [9:0] CSET_A_FLASH_ON_LINE_HI = 10'h297;
   localparam int CSET_NREG = 39;

   // values after reset, by index from the first address
   localparam logic [5:0] CSET_RST [CSET_NREG] = '{
      6'h01, 6'h0b, 6'h01, 6'h05, 6'h02, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
      6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h02, 6'h00, 6'h00, 6'h01,
      6'h00, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
      6'h00, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00};
   // implemented bits of each register; the rest read as zero
   localparam logic [5:0] CSET_MASK [CSET_NREG] = '{
      6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
      6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h07, 6'h07, 6'h01, 6'h01, 6'h01,
      6'h3f, 6'h3f, 6'h01, 6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
      6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f};

   localparam logic [11:0] CSET_CNT_RST = 12'h000;
   localparam logic [2:0] CSET_TRIG_RST = 3'h0;
   localparam logic CSET_CLEAR_OUT_RST = 1'b1;
   localparam logic CSET_DRIVE_OUT_RST = 1'b0;

   typedef enum logic [3:0] {
      CSET_IDLE = 4'b0001,
      CSET_ARM = 4'b0010,
      CSET_EXPOSE = 4'b0100,
      CSET_READ = 4'b1000
   } cset_state_e;

   typedef struct packed {
      logic en;
      logic [9:0] addr;
      logic [5:0] data;
   } cset_wr_s;

   function automatic logic [5:0] cset_ix(input logic [9:0] a);
      logic [9:0] d;
      d = a - CSET_A_SUB_CLEAR_START_POLARITY;
      return d[5:0];
   endfunction
endpackage

// ==== cset_core.sv ====
// Overview of operation
// - clearing pulse: start polarity, two pulses per line, two 12-bit toggles each
// - a programmable 12-bit count of clearing pulses per field, then none till next field
// - after the sensor gate line, suppress a six-bit number of clearing pulses
// - exposure suppresses clearing and sensor gate pulses for a 12-bit field count
// - sync-disable bit holds vertical and horizontal syncs off during exposure
// - trigger bits start bias (bit 0), shutter (bit 1) and flash (bit 2)
// - three-bit readout field, reset two, sets clearing suppression after exposure
// - keep-on 0 drops bias after readout or next vertical sync; 1 keeps it
// - shutter driven only when enabled, enable aligned to vertical sync
// - shutter on at 12-bit line from vertical sync, then 12-bit pixel offset
// - shutter off field: 12-bit vertical sync count from last clearing field
// - shutter off line: 12-bit horizontal sync count within the off field
// - shutter off pixel: 12-bit pixel count within the off line
// - flash on field: 12-bit vertical sync count from last clearing field
// - flash on line: 12-bit horizontal sync count within the on field
`timescale 1ns/1ps
`default_nettype none
module cset_core
   import cset_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire cset_wr_s reg_wr,
   input wire logic [9:0] rd_addr,
   output logic [5:0] rd_data,
   input wire logic vertical_sync,
   input wire logic horizontal_sync,
   input wire logic sg_line,
   output logic substrate_clear_pulse,
   output logic substrate_bias_signal,
   output logic mech_shutter_out,
   output logic flash_strobe_out,
   output logic sync_hold,
   output logic sensor_gate_block,
   output logic seq_busy
);
   // ---------------- register file ----------------
   wire logic [5:0] regv [CSET_NREG];
   wire logic wr_hit = reg_wr.en && reg_wr.addr >= CSET_A_SUB_CLEAR_START_POLARITY
      && reg_wr.addr <= CSET_A_FLASH_ON_LINE_HI;
   wire logic [5:0] wr_ix = cset_ix(reg_wr.addr);
   wire logic rd_hit = rd_addr >= CSET_A_SUB_CLEAR_START_POLARITY
      && rd_addr <= CSET_A_FLASH_ON_LINE_HI;
   wire logic [5:0] rd_ix = cset_ix(rd_addr);

   generate
      for (genvar g = 0; g < CSET_NREG; g++) begin : g_reg
         logic [5:0] q;
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               q <= CSET_RST[g];
            end else if (wr_hit && wr_ix == 6'(g)) begin
               q <= reg_wr.data & CSET_MASK[g];
            end
         end
         assign regv[g] = q;
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 6'h00;
      end else begin
         rd_data <= rd_hit ? regv[rd_ix] : 6'h00;
      end
   end

   // 12-bit settings from lo/hi pairs
   wire logic [11:0] sc1_t1 = {regv[cset_ix(CSET_A_SUB_CLEAR1_TOGGLE1_HI)],
      regv[cset_ix(CSET_A_SUB_CLEAR1_TOGGLE1_LO)]};
   wire logic [11:0] sc1_t2 = {regv[cset_ix(CSET_A_SUB_CLEAR1_TOGGLE2_HI)],
      regv[cset_ix(CSET_A_SUB_CLEAR1_TOGGLE2_LO)]};
   wire logic [11:0] sc2_t1 = {regv[cset_ix(CSET_A_SUB_CLEAR2_TOGGLE1_HI)],
      regv[cset_ix(CSET_A_SUB_CLEAR2_TOGGLE1_LO)]};
   wire logic [11:0] sc2_t2 = {regv[cset_ix(CSET_A_SUB_CLEAR2_TOGGLE2_HI)],
      regv[cset_ix(CSET_A_SUB_CLEAR2_TOGGLE2_LO)]};
   wire logic [11:0] sub_clear_count = {regv[cset_ix(CSET_A_SUB_CLEAR_COUNT_HI)],
      regv[cset_ix(CSET_A_SUB_CLEAR_COUNT_LO)]};
   wire logic [11:0] exposure_fields = {regv[cset_ix(CSET_A_EXPOSURE_FIELDS_HI)],
      regv[cset_ix(CSET_A_EXPOSURE_FIELDS_LO)]};
   wire logic [11:0] bias_on_pos = {regv[cset_ix(CSET_A_BIAS_ON_POS_HI)],
      regv[cset_ix(CSET_A_BIAS_ON_POS_LO)]};
   wire logic [11:0] shutter_on_line = {regv[cset_ix(CSET_A_SHUTTER_ON_LINE_HI)],
      regv[cset_ix(CSET_A_SHUTTER_ON_LINE_LO)]};
   wire logic [11:0] shutter_on_pixel = {regv[cset_ix(CSET_A_SHUTTER_ON_PIXEL_HI)],
      regv[cset_ix(CSET_A_SHUTTER_ON_PIXEL_LO)]};
   wire logic [11:0] shutter_off_field = {regv[cset_ix(CSET_A_SHUTTER_OFF_FIELD_HI)],
      regv[cset_ix(CSET_A_SHUTTER_OFF_FIELD_LO)]};
   wire logic [11:0] shutter_off_line = {regv[cset_ix(CSET_A_SHUTTER_OFF_LINE_HI)],
      regv[cset_ix(CSET_A_SHUTTER_OFF_LINE_LO)]};
   wire logic [11:0] shutter_off_pixel = {regv[cset_ix(CSET_A_SHUTTER_OFF_PIXEL_HI)],
      regv[cset_ix(CSET_A_SHUTTER_OFF_PIXEL_LO)]};
   wire logic [11:0] flash_on_field = {regv[cset_ix(CSET_A_FLASH_ON_FIELD_HI)],
      regv[cset_ix(CSET_A_FLASH_ON_FIELD_LO)]};
   wire logic [11:0] flash_on_line = {regv[cset_ix(CSET_A_FLASH_ON_LINE_HI)],
      regv[cset_ix(CSET_A_FLASH_ON_LINE_LO)]};
   wire logic sc_pol = regv[cset_ix(CSET_A_SUB_CLEAR_START_POLARITY)][0];
   wire logic [5:0] gate_suppress = regv[cset_ix(CSET_A_SUB_CLEAR_GATE_SUPPRESS)];
   wire logic sync_off = regv[cset_ix(CSET_A_SYNC_OFF_IN_EXPOSURE)][0];
   wire logic [2:0] trigger = regv[cset_ix(CSET_A_SEQUENCE_TRIGGER)][2:0];
   wire logic [2:0] readout = regv[cset_ix(CSET_A_READOUT_CLEAR_SUPPRESS)][2:0];
   wire logic bias_mode = regv[cset_ix(CSET_A_BIAS_READOUT_MODE)][0];
   wire logic bias_keep = regv[cset_ix(CSET_A_BIAS_KEEP_ACTIVE)][0];
   wire logic bias_pol = regv[cset_ix(CSET_A_BIAS_POLARITY)][0];
   wire logic shutter_enable = regv[cset_ix(CSET_A_SHUTTER_ENABLE)][0];
   wire logic shutter_pol = regv[cset_ix(CSET_A_SHUTTER_POLARITY)][0];
   wire logic flash_pol = regv[cset_ix(CSET_A_FLASH_POLARITY)][0];

   // ---------------- position counters ----------------
   logic [11:0] pix_cnt;
   logic [11:0] line_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pix_cnt <= CSET_CNT_RST;
      end else if (horizontal_sync) begin
         pix_cnt <= CSET_CNT_RST;
      end else begin
         pix_cnt <= pix_cnt + 12'h001;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_cnt <= CSET_CNT_RST;
      end else if (vertical_sync) begin
         line_cnt <= CSET_CNT_RST;
      end else if (horizontal_sync) begin
         line_cnt <= line_cnt + 12'h001;
      end
   end

   // ---------------- exposure sequencer ----------------
   cset_state_e state;
   cset_state_e next_state;
   logic trig_pend;
   logic [2:0] trig_q;
   logic [11:0] fd_cnt;
   logic [2:0] rd_fld;
   // a start written while one is running waits for the sequence to finish
   wire logic trig_wr = wr_hit && reg_wr.addr == CSET_A_SEQUENCE_TRIGGER
      && reg_wr.data[2:0] != 3'h0;
   wire logic in_idle = state == CSET_IDLE;
   wire logic in_arm = state == CSET_ARM;
   wire logic in_exp = state == CSET_EXPOSE;
   wire logic in_read = state == CSET_READ;
   wire logic exp_done = fd_cnt >= exposure_fields;
   wire logic [2:0] rd_fld_inc = rd_fld + 3'h1;
   wire logic read_done = rd_fld_inc >= readout;

   always_comb begin
      next_state = state;
      case (state)
         CSET_IDLE: begin
            if (vertical_sync && trig_pend) begin
               next_state = CSET_ARM;
            end
         end
         CSET_ARM: begin
            if (vertical_sync) begin
               next_state = (exposure_fields == CSET_CNT_RST) ? CSET_READ : CSET_EXPOSE;
            end
         end
         CSET_EXPOSE: begin
            if (vertical_sync && exp_done) begin
               next_state = CSET_READ;
            end
         end
         CSET_READ: begin
            if (vertical_sync && read_done) begin
               next_state = CSET_IDLE;
            end
         end
         default: begin
            next_state = CSET_IDLE;
         end
      endcase
   end

   wire logic arm_go = in_idle && next_state == CSET_ARM;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= CSET_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // the write wins over the take, so a start is never lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_pend <= 1'b0;
      end else begin
         trig_pend <= trig_wr || (trig_pend && !arm_go);
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_q <= CSET_TRIG_RST;
      end else if (arm_go) begin
         trig_q <= trigger;
      end
   end
   // field zero is the field holding the last clearing pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fd_cnt <= CSET_CNT_RST;
      end else if (arm_go) begin
         fd_cnt <= CSET_CNT_RST;
      end else if (vertical_sync && !in_idle) begin
         fd_cnt <= fd_cnt + 12'h001;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_fld <= 3'h0;
      end else if (!in_read) begin
         rd_fld <= 3'h0;
      end else if (vertical_sync) begin
         rd_fld <= rd_fld_inc;
      end
   end

   // ---------------- substrate clearing pulse ----------------
   logic [11:0] sub_cnt;
   logic [5:0] supp_cnt;
   logic line_on;
   wire logic seq_block = in_exp || (in_read && rd_fld < readout);
   // the field's first line counts against a fresh total, not the last field's
   wire logic [11:0] sub_base = vertical_sync ? CSET_CNT_RST : sub_cnt;
   wire logic count_left = sub_base < sub_clear_count;
   wire logic line_go = !seq_block && count_left && supp_cnt == 6'h00;
   wire logic [11:0] next_sub_cnt = line_go ? sub_base + 12'h001 : sub_base;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sub_cnt <= CSET_CNT_RST;
      end else if (horizontal_sync || vertical_sync) begin
         sub_cnt <= next_sub_cnt;
      end
   end
   // sg_line loads the count; each later line burns one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supp_cnt <= 6'h00;
      end else if (sg_line) begin
         supp_cnt <= gate_suppress;
      end else if (horizontal_sync && supp_cnt != 6'h00) begin
         supp_cnt <= supp_cnt - 6'h01;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_on <= 1'b0;
      end else if (vertical_sync && (in_arm || in_exp)) begin
         line_on <= 1'b0;
      end else if (horizontal_sync) begin
         line_on <= line_go;
      end
   end
   // an all-ones first toggle leaves no pixel below the second, so that pulse never fires
   wire logic win1 = pix_cnt >= sc1_t1 && pix_cnt < sc1_t2;
   wire logic win2 = pix_cnt >= sc2_t1 && pix_cnt < sc2_t2;
   wire logic next_clear = line_on ? (sc_pol ^ win1 ^ win2) : sc_pol;

   // ---------------- bias, shutter, flash ----------------
   logic bias_act;
   logic shut_act;
   logic flash_act;
   logic sh_en_q;
   wire logic bias_on = in_arm && trig_q[0] && line_cnt == bias_on_pos && pix_cnt == 12'h000;
   // zero exposure fields go from arm straight to readout, so key on readout entry
   wire logic read_entry = !in_read && next_state == CSET_READ;
   wire logic bias_off = bias_keep
      ? (in_idle && !trigger[0])
      : (vertical_sync && (bias_mode ? (in_read && read_done) : read_entry));
   wire logic shut_on = in_arm && trig_q[1] && sh_en_q && line_cnt == shutter_on_line
      && pix_cnt == shutter_on_pixel;
   wire logic shut_off = !in_idle && fd_cnt == shutter_off_field
      && line_cnt == shutter_off_line && pix_cnt == shutter_off_pixel;
   wire logic flash_on = !in_idle && trig_q[2] && fd_cnt == flash_on_field
      && line_cnt == flash_on_line && pix_cnt == 12'h000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_en_q <= 1'b0;
      end else if (vertical_sync) begin
         sh_en_q <= shutter_enable;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bias_act <= 1'b0;
      end else if (bias_on) begin
         bias_act <= 1'b1;
      end else if (bias_off) begin
         bias_act <= 1'b0;
      end
   end
   // enable dropped mid-sequence closes the shutter at the next field
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shut_act <= 1'b0;
      end else if (shut_off || !sh_en_q) begin
         shut_act <= 1'b0;
      end else if (shut_on) begin
         shut_act <= 1'b1;
      end
   end
   // flash has no programmed off point here; it ends with the sequence
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_act <= 1'b0;
      end else if (flash_on) begin
         flash_act <= 1'b1;
      end else if (in_idle) begin
         flash_act <= 1'b0;
      end
   end

   // ---------------- registered outputs ----------------
   // polarity applied in the flop, so a polarity write cannot glitch a pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         substrate_clear_pulse <= CSET_CLEAR_OUT_RST;
         substrate_bias_signal <= CSET_DRIVE_OUT_RST;
         mech_shutter_out <= CSET_DRIVE_OUT_RST;
         flash_strobe_out <= CSET_DRIVE_OUT_RST;
         sync_hold <= 1'b0;
         sensor_gate_block <= 1'b0;
         seq_busy <= 1'b0;
      end else begin
         substrate_clear_pulse <= next_clear;
         substrate_bias_signal <= bias_act ? bias_pol : !bias_pol;
         mech_shutter_out <= shut_act ? shutter_pol : !shutter_pol;
         flash_strobe_out <= flash_act ? flash_pol : !flash_pol;
         sync_hold <= sync_off && in_exp;
         sensor_gate_block <= in_exp;
         seq_busy <= !in_idle || trig_pend;
      end
   end

   // ---------------- checks ----------------
   chk_exposure_end_read: assert property (@(posedge clk) disable iff (!rst_b)
      in_exp && vertical_sync && exp_done |=> in_read)
      else $error("exposure did not end after programmed fields");
   chk_exposure_gate_block: assert property (@(posedge clk) disable iff (!rst_b)
      in_exp |=> sensor_gate_block && substrate_clear_pulse == $past(sc_pol))
      else $error("gate or clearing pulse not suppressed in exposure");
   chk_sync_hold_on: assert property (@(posedge clk) disable iff (!rst_b)
      in_exp && sync_off |=> sync_hold)
      else $error("syncs not held off during exposure");
   chk_clear_count_stop: assert property (@(posedge clk) disable iff (!rst_b)
      horizontal_sync && !vertical_sync && !count_left |=> !line_on)
      else $error("clearing pulse issued past field count");
   chk_gate_suppress_line: assert property (@(posedge clk) disable iff (!rst_b)
      horizontal_sync && supp_cnt != 6'h00 |=> !line_on)
      else $error("clearing pulse not suppressed after gate line");
   chk_shutter_enable_gate: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(shut_act) |-> $past(sh_en_q) && $past(in_arm))
      else $error("shutter opened without aligned enable");
   chk_bias_drop_read: assert property (@(posedge clk) disable iff (!rst_b)
      in_exp && vertical_sync && exp_done && !bias_keep && !bias_mode |=> ##1
      substrate_bias_signal == !$past(bias_pol))
      else $error("bias not dropped at readout start");
   chk_flash_on_point: assert property (@(posedge clk) disable iff (!rst_b)
      flash_on |=> ##1 flash_strobe_out == $past(flash_pol))
      else $error("flash not driven at its on line");
   chk_readout_clear_off: assert property (@(posedge clk) disable iff (!rst_b)
      in_read && rd_fld < readout && horizontal_sync && !vertical_sync |=> !line_on)
      else $error("clearing pulse during suppressed readout field");
endmodule
`default_nettype wire

// ==== cset_sync_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module cset_sync_gen #(
   parameter int LINE_LEN = 16,
   parameter int LINES = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   output logic vertical_sync,
   output logic horizontal_sync,
   output logic sg_line
);
   int pix;
   int ln;
   // moves on the falling edge so the core samples settled pulses
   always @(negedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pix <= 0;
         ln <= 0;
      end else begin
         pix <= (pix == LINE_LEN - 1) ? 0 : pix + 1;
         if (pix == LINE_LEN - 1) begin
            ln <= (ln == LINES - 1) ? 0 : ln + 1;
         end
      end
   end
   // a field start always lands on a line start
   assign horizontal_sync = rst_b && pix == 0;
   assign vertical_sync = horizontal_sync && ln == 0;
   assign sg_line = horizontal_sync && ln == LINES - 2;
endmodule
`default_nettype wire

// ==== cset_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cset_core_tb_top;
   import cset_pkg::*;
   typedef struct packed {
      logic [9:0] addr;
      logic [5:0] wdata;
      logic [5:0] exp;
   } cset_row_s;
   localparam cset_row_s ROWS [7] = '{'{10'h271, 6'h3f, 6'h01}, '{10'h27a, 6'h2a, 6'h2a},
      '{10'h27b, 6'h15, 6'h15}, '{10'h27f, 6'h3e, 6'h00}, '{10'h281, 6'h3f, 6'h07},
      '{10'h270, 6'h3f, 6'h00}, '{10'h298, 6'h3f, 6'h00}};
   // pulse low on pixels 2..3; exposure 2 fields; shutter, bias and flash placed in lines
   localparam logic [15:0] SETUP [16] = '{{10'h272, 6'h02}, {10'h273, 6'h00},
      {10'h274, 6'h04}, {10'h275, 6'h00}, {10'h27b, 6'h00}, {10'h27d, 6'h02},
      {10'h281, 6'h02}, {10'h27f, 6'h01}, {10'h287, 6'h01}, {10'h289, 6'h01},
      {10'h28b, 6'h02}, {10'h28d, 6'h03}, {10'h28f, 6'h01}, {10'h294, 6'h01},
      {10'h296, 6'h02}, {10'h285, 6'h01}};
   localparam logic [5:0] CNT [4] = '{6'h00, 6'h03, 6'h08, 6'h3f};
   localparam int EXPF [4] = '{0, 3, 8, 8};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   cset_wr_s reg_wr = '0;
   logic [9:0] rd_addr = '0;
   logic [5:0] rd_data;
   logic vertical_sync, horizontal_sync, sg_line;
   logic clr, bias, shut, flash, hold, gblk, busy;
   logic prev_clr = 1'b1;
   logic prev_gblk = 1'b0;
   logic bias_at_read = 1'b1;
   logic [4:0] seen = '0;
   int error_cnt = 0;
   int samples_checked = 0;
   int n, i, falls, gfalls;
   always #4 clk = ~clk;
   cset_sync_gen u_cset_sync_gen (.clk(clk), .rst_b(rst_b), .vertical_sync(vertical_sync),
      .horizontal_sync(horizontal_sync), .sg_line(sg_line));
   cset_core u_cset_core (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
      .sg_line(sg_line), .substrate_clear_pulse(clr), .substrate_bias_signal(bias),
      .mech_shutter_out(shut), .flash_strobe_out(flash), .sync_hold(hold),
      .sensor_gate_block(gblk), .seq_busy(busy));
   always @(posedge clk) begin
      if (prev_clr && !clr) begin
         falls++;
         if (gblk) gfalls++;
      end
      prev_clr <= clr;
      prev_gblk <= gblk;
      if (prev_gblk && !gblk) bias_at_read <= bias;
      if (busy) seen <= seen | {hold, gblk, bias, shut, flash};
   end
   task complete_run;
      $display("comparisons %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [9:0] a, input logic [5:0] d);
      reg_wr <= {1'b1, a, d};
      @(negedge clk);
      reg_wr.en <= 1'b0;
      @(negedge clk);
   endtask
   task rd(input logic [9:0] a, input logic [5:0] e);
      rd_addr <= a;
      repeat (2) @(negedge clk);
      chk(rd_data, e);
   endtask
   // bounded waits; running out counts as a mismatch
   task wait_vs;
      for (n = 0; n < 300 && vertical_sync !== 1'b1; n++) @(negedge clk);
      if (n == 300) error_cnt++;
      if (n == 300) complete_run;
   endtask
   task wait_idle;
      for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk);
      if (n == 2000) error_cnt++;
      if (n == 2000) complete_run;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk({bias, shut, flash, clr, busy}, 5'h02);
      for (i = 0; i < CSET_NREG; i++) rd(10'h271 + 10'(i), CSET_RST[i]);
      foreach (ROWS[i]) begin
         wr(ROWS[i].addr, ROWS[i].wdata);
         rd(ROWS[i].addr, ROWS[i].exp);
      end
      foreach (SETUP[i]) wr(SETUP[i][15:6], SETUP[i][5:0]);
      for (i = 0; i < 4; i++) begin
         wr(10'h27a, CNT[i]);
         wait_vs;
         falls = 0;
         repeat (128) @(negedge clk);
         chk(12'(falls), 12'(EXPF[i]));
      end
      // two lines lost per gate line: the last of this field, the first of the next
      wr(10'h27c, 6'h02);
      repeat (130) @(negedge clk);
      wait_vs;
      falls = 0;
      repeat (128) @(negedge clk);
      chk(12'(falls), 12'h006);
      wr(10'h27c, 6'h00);
      // idle level follows polarity
      wr(10'h293, 6'h00);
      @(negedge clk);
      chk(flash, 1'b1);
      wr(10'h293, 6'h01);
      chk(busy, 1'b0);
      wr(10'h280, 6'h07);
      @(posedge clk);
      #1;
      chk(busy, 1'b1);
      seen = '0;
      gfalls = 0;
      wait_idle;
      chk(seen, 5'h1f);
      chk(12'(gfalls), 12'h000);
      chk(bias_at_read, 1'b0);
      repeat (2) @(negedge clk);
      chk({hold, gblk, bias, shut, flash}, 5'h00);
      // keep-on: bias outlives the sequence until the trigger bit is cleared
      wr(10'h283, 6'h01);
      wr(10'h280, 6'h01);
      @(negedge clk);
      wait_idle;
      chk(bias, 1'b1);
      wr(10'h280, 6'h00);
      repeat (2) @(negedge clk);
      chk(bias, 1'b0);
      // readout mode: bias outlives exposure and drops when readout ends
      wr(10'h283, 6'h00);
      wr(10'h282, 6'h01);
      bias_at_read = 1'b0;
      wr(10'h280, 6'h01);
      @(negedge clk);
      wait_idle;
      chk({bias_at_read, bias}, 2'h2);
      complete_run;
   end
endmodule
`default_nettype wire
